//--- design/hps_consts.svh
// Constants for the host port strobe handshake: timing counts and access codes
`ifndef HPS_CONSTS_SVH
`define HPS_CONSTS_SVH

// ==========================================================================
// Clock and strobe timing
// ==========================================================================
`define HPS_CLK_PERIOD_PS 100000
`define HPS_STB_LOW_MIN_PS 12500
`define HPS_STB_MIN_P 4
// Least time, so rounded up; the larger of 4P and 12.5 ns
`define HPS_STB_LOW_NS_CYC ((`HPS_STB_LOW_MIN_PS + `HPS_CLK_PERIOD_PS - 1) / `HPS_CLK_PERIOD_PS)
`define HPS_STB_LOW_CYC ((`HPS_STB_LOW_NS_CYC > `HPS_STB_MIN_P) ? `HPS_STB_LOW_NS_CYC : `HPS_STB_MIN_P)
`define HPS_STB_HIGH_CYC `HPS_STB_MIN_P
`define HPS_CNT_W 4

// ==========================================================================
// Access types
// ==========================================================================
`define HPS_ACC_CTRL 2'h0
`define HPS_ACC_ADDR 2'h1
`define HPS_ACC_DATA_INC 2'h2
`define HPS_ACC_DATA_FIX 2'h3

`endif

//--- design/hps_device_end.sv
// Device end of the host port: strobe decode, ready stall and bus turnaround
`timescale 1ns/100ps
`default_nettype none
`include "hps_consts.svh"

// ==========================================================================
// Contract
// - Strobe is NOT(strobe one XOR two) OR select
// - Host presents type, direction, half-word selects
// - Host holds strobe low at least 4P
// - Host keeps strobe high 4P between accesses
// - Host releases strobe only after ready low
// - Word or first-half read fetches, ready high; the code fetches for data reads only, control and address reads do not fetch
// - Full write buffer raises ready until space; data writes only, control and address writes do not stall
// - Ready rises within 4P plus 8 ns
// - Drive bus only for reads, release after rise
// - Second half-word read served without fetching
// - Data valid before ready low, held past rise; a fetched read sets data and ready low on the same edge
// - Host pulses address strobe once per access
// - Address strobe low across strobe falling edge
// - Host write data held across strobe rise
module hps_device_end (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, high
    hps_link_if.device link, // Pins from the host
    input wire logic sixteen_bit_mode, // 1: 16-bit port, 0: 32-bit port
    output logic dma_read_req, // Fetch request to the address generator, pulse
    input wire logic [31:0] dma_read_data, // Fetched word
    input wire logic dma_read_valid, // Fetched word valid, pulse
    input wire logic [31:0] ctrl_read_data, // Data for control and address reads
    input wire logic write_buffer_full, // Internal write buffer has no space
    output logic write_push, // Completed write, pulse
    output logic [31:0] write_data, // Word of the completed write
    output logic [1:0] write_type // Access type of the completed write
);
    hps_pkg::hps_dev_s s;
    hps_pkg::hps_dev_s next_s;
    logic strobe_n;
    logic fall;
    logic rise;
    logic as_fall;
    logic [1:0] f_type;
    logic f_read;
    logic f_half;
    logic f_data;

    // 16-bit mode carries half-words in the low lanes
    function automatic logic [31:0] hps_half(input logic [31:0] w, input logic upper);
        hps_half = upper ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
    endfunction

    function automatic logic hps_is_data(input logic [1:0] t);
        hps_is_data = (t == `HPS_ACC_DATA_INC) || (t == `HPS_ACC_DATA_FIX);
    endfunction

    // ======================================================================
    // Strobe decode and select latching
    // ======================================================================
    assign strobe_n = ~(link.data_strobe_one ^ link.data_strobe_two) | link.port_chip_select_n;
    assign fall = s.strobe_n_q & ~strobe_n;
    assign rise = ~s.strobe_n_q & strobe_n;
    assign as_fall = s.as_n_q & ~link.address_strobe_n;

    // Selects caught by the address strobe win over the live pins
    always_comb
    begin
        f_type = s.as_taken ? s.sel_type : link.access_type_select;
        f_read = s.as_taken ? s.sel_read : link.read_write_select;
        f_half = s.as_taken ? s.sel_half : link.half_word_select;
        f_data = hps_is_data(f_type);
    end

    // ======================================================================
    // Access handling
    // ======================================================================
    always_comb
    begin
        next_s = s;
        next_s.dma_req = 1'b0;
        next_s.push = 1'b0;
        next_s.strobe_n_q = strobe_n;
        next_s.as_n_q = link.address_strobe_n;
        // Only the first address strobe of an access counts
        if (as_fall && !s.as_taken)
        begin
            next_s.as_taken = 1'b1;
            next_s.sel_type = link.access_type_select;
            next_s.sel_read = link.read_write_select;
            next_s.sel_half = link.half_word_select;
        end
        // Last sample while the strobe is low is what a write commits
        if (!strobe_n)
        begin
            next_s.in_data = link.port_data_bus;
        end
        case (s.st)
            hps_pkg::HPS_D_IDLE:
            begin
                if (fall)
                begin
                    next_s.sel_type = f_type;
                    next_s.sel_read = f_read;
                    next_s.sel_half = f_half;
                    next_s.st = hps_pkg::HPS_D_ACTIVE;
                    if (f_read)
                    begin
                        next_s.drive_n = 1'b0;
                        if (f_data && (!sixteen_bit_mode || !f_half))
                        begin
                            // Stall until the fetched word is in the data register
                            next_s.dma_req = 1'b1;
                            next_s.ready_n = 1'b1;
                            next_s.st = hps_pkg::HPS_D_FETCH;
                        end
                        else if (f_data)
                        begin
                            next_s.data_out = hps_half(s.data_reg, 1'b1);
                        end
                        else
                        begin
                            next_s.data_out = ctrl_read_data;
                        end
                    end
                    else if (f_data && write_buffer_full)
                    begin
                        next_s.ready_n = 1'b1;
                        next_s.st = hps_pkg::HPS_D_WAIT_SPACE;
                    end
                end
            end
            hps_pkg::HPS_D_FETCH:
            begin
                if (dma_read_valid)
                begin
                    // Data and ready low leave on the same edge
                    next_s.data_reg = dma_read_data;
                    next_s.data_out = sixteen_bit_mode ? hps_half(dma_read_data, 1'b0) : dma_read_data;
                    next_s.ready_n = 1'b0;
                    next_s.st = hps_pkg::HPS_D_ACTIVE;
                end
            end
            hps_pkg::HPS_D_WAIT_SPACE:
            begin
                if (!write_buffer_full)
                begin
                    next_s.ready_n = 1'b0;
                    next_s.st = hps_pkg::HPS_D_ACTIVE;
                end
            end
            hps_pkg::HPS_D_ACTIVE:
            begin
                // Write commits at the strobe rise
                if (rise && !s.sel_read)
                begin
                    if (hps_is_data(s.sel_type) && sixteen_bit_mode && !s.sel_half)
                    begin
                        next_s.data_reg[15:0] = s.in_data[15:0];
                    end
                    else
                    begin
                        next_s.push = 1'b1;
                        next_s.push_type = s.sel_type;
                        next_s.push_data = (hps_is_data(s.sel_type) && sixteen_bit_mode) ?
                                           {s.in_data[15:0], s.data_reg[15:0]} : s.in_data;
                    end
                end
            end
            default:
            begin
                next_s.st = hps_pkg::HPS_D_IDLE;
            end
        endcase
        // Strobe rise ends any access; a stalled one is abandoned
        if (rise)
        begin
            next_s.st = hps_pkg::HPS_D_IDLE;
            next_s.drive_n = 1'b1;
            next_s.ready_n = 1'b0;
            next_s.as_taken = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s <= '{st: hps_pkg::HPS_D_IDLE, strobe_n_q: 1'b1, as_n_q: 1'b1, as_taken: 1'b0,
                   sel_type: '0, sel_read: 1'b0, sel_half: 1'b0, data_reg: '0, in_data: '0,
                   ready_n: 1'b0, drive_n: 1'b1, data_out: '0, dma_req: 1'b0, push: 1'b0,
                   push_data: '0, push_type: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign link.port_ready_n = s.ready_n;
    assign link.dev_data_out = s.data_out;
    assign link.dev_data_oe_n = s.drive_n;
    assign dma_read_req = s.dma_req;
    assign write_push = s.push;
    assign write_data = s.push_data;
    assign write_type = s.push_type;
endmodule // hps_device_end

`default_nettype wire

//--- design/hps_host_end.sv
// Host end of the host port: runs one strobed access per command
`timescale 1ns/100ps
`default_nettype none
`include "hps_consts.svh"

module hps_host_end #(
    parameter int STB_LOW_CYC = `HPS_STB_LOW_CYC,
    parameter int STB_HIGH_CYC = `HPS_STB_HIGH_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst, // Synchronous reset, high
    hps_link_if.host link, // Pins toward the device
    input wire logic use_address_strobe, // Pulse the address strobe per access
    input wire logic cmd_valid, // Command offered
    output logic cmd_ready, // Command accepted when high with valid
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic [1:0] cmd_type, // Access type
    input wire logic cmd_half, // Half-word select in 16-bit mode
    input wire logic [31:0] cmd_data, // Write data
    output logic rsp_valid, // Access finished, one cycle
    output logic [31:0] rsp_data // Read data, zero for writes
);
    localparam logic [`HPS_CNT_W-1:0] LOW_CYC = `HPS_CNT_W'(STB_LOW_CYC);
    localparam logic [`HPS_CNT_W-1:0] HIGH_CYC = `HPS_CNT_W'(STB_HIGH_CYC);

    hps_pkg::hps_host_s s;
    hps_pkg::hps_host_s next_s;

    // ======================================================================
    // Access sequencer
    // ======================================================================
    always_comb
    begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        case (s.st)
            hps_pkg::HPS_H_IDLE:
            begin
                if (cmd_valid && s.cmd_ready)
                begin
                    // Selects settle a cycle ahead of the strobe edge
                    next_s.acc_type = cmd_type;
                    next_s.rd = !cmd_write;
                    next_s.half = cmd_half;
                    next_s.dout = cmd_data;
                    next_s.oe_n = !cmd_write;
                    next_s.cs_n = 1'b0;
                    next_s.as_n = !use_address_strobe;
                    next_s.cmd_ready = 1'b0;
                    next_s.st = hps_pkg::HPS_H_SETUP;
                end
            end
            hps_pkg::HPS_H_SETUP:
            begin
                next_s.ds_one = 1'b0;
                next_s.cnt = `HPS_CNT_W'(1);
                next_s.st = hps_pkg::HPS_H_STROBE;
            end
            hps_pkg::HPS_H_STROBE:
            begin
                // Release only after the least low time and ready low
                if (s.cnt >= LOW_CYC && !link.port_ready_n)
                begin
                    next_s.ds_one = 1'b1;
                    next_s.cs_n = 1'b1;
                    next_s.as_n = 1'b1;
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_data = s.rd ? link.port_data_bus : 32'h00000000;
                    next_s.cnt = `HPS_CNT_W'(1);
                    next_s.st = hps_pkg::HPS_H_HOLD;
                end
                else if (s.cnt < LOW_CYC)
                begin
                    next_s.cnt = s.cnt + `HPS_CNT_W'(1);
                end
            end
            hps_pkg::HPS_H_HOLD:
            begin
                // Write data stays one cycle past the strobe rise
                next_s.oe_n = 1'b1;
                next_s.cnt = s.cnt + `HPS_CNT_W'(1);
                next_s.st = hps_pkg::HPS_H_GAP;
            end
            hps_pkg::HPS_H_GAP:
            begin
                if (s.cnt >= HIGH_CYC)
                begin
                    next_s.cmd_ready = 1'b1;
                    next_s.st = hps_pkg::HPS_H_IDLE;
                end
                else
                begin
                    next_s.cnt = s.cnt + `HPS_CNT_W'(1);
                end
            end
            default:
            begin
                next_s.st = hps_pkg::HPS_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s <= '{st: hps_pkg::HPS_H_IDLE, cnt: '0, cs_n: 1'b1, ds_one: 1'b1, as_n: 1'b1,
                   acc_type: '0, rd: 1'b0, half: 1'b0, dout: '0, oe_n: 1'b1,
                   cmd_ready: 1'b1, rsp_valid: 1'b0, rsp_data: '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // Data strobe two idles high; strobing strobe one alone makes them differ
    assign link.port_chip_select_n = s.cs_n;
    assign link.data_strobe_one = s.ds_one;
    assign link.data_strobe_two = 1'b1;
    assign link.address_strobe_n = s.as_n;
    assign link.access_type_select = s.acc_type;
    assign link.read_write_select = s.rd;
    assign link.half_word_select = s.half;
    assign link.host_data_out = s.dout;
    assign link.host_data_oe_n = s.oe_n;
    assign cmd_ready = s.cmd_ready;
    assign rsp_valid = s.rsp_valid;
    assign rsp_data = s.rsp_data;
endmodule // hps_host_end

`default_nettype wire

//--- design/hps_link_if.sv
// Pin-level link between the host end and the device end of the host port
`timescale 1ns/100ps
`default_nettype none

interface hps_link_if;
    logic port_chip_select_n;
    logic data_strobe_one;
    logic data_strobe_two;
    logic address_strobe_n;
    logic [1:0] access_type_select;
    logic read_write_select;
    logic half_word_select;
    logic port_ready_n;
    logic [31:0] host_data_out;
    logic host_data_oe_n;
    logic [31:0] dev_data_out;
    logic dev_data_oe_n;
    wire [31:0] port_data_bus;

    // Enables low while driving; an idle bus rests at its pull-ups
    assign port_data_bus = !dev_data_oe_n ? dev_data_out :
                           (!host_data_oe_n ? host_data_out : 32'hffffffff);

    modport device (
        input port_chip_select_n,
        input data_strobe_one,
        input data_strobe_two,
        input address_strobe_n,
        input access_type_select,
        input read_write_select,
        input half_word_select,
        input port_data_bus,
        output port_ready_n,
        output dev_data_out,
        output dev_data_oe_n
    );

    modport host (
        output port_chip_select_n,
        output data_strobe_one,
        output data_strobe_two,
        output address_strobe_n,
        output access_type_select,
        output read_write_select,
        output half_word_select,
        output host_data_out,
        output host_data_oe_n,
        input port_ready_n,
        input port_data_bus
    );
endinterface

`default_nettype wire

//--- design/hps_pkg.sv
// Types shared by both ends of the host port strobe handshake
`default_nettype none
package hps_pkg;

    // ======================================================================
    // Device end
    // ======================================================================
    typedef enum logic [2:0] {
        HPS_D_IDLE,
        HPS_D_FETCH,
        HPS_D_WAIT_SPACE,
        HPS_D_ACTIVE
    } hps_dev_state_e;

    typedef struct packed {
        hps_dev_state_e st;
        logic strobe_n_q;
        logic as_n_q;
        logic as_taken;
        logic [1:0] sel_type;
        logic sel_read;
        logic sel_half;
        logic [31:0] data_reg;
        logic [31:0] in_data;
        logic ready_n;
        logic drive_n;
        logic [31:0] data_out;
        logic dma_req;
        logic push;
        logic [31:0] push_data;
        logic [1:0] push_type;
    } hps_dev_s;

    // ======================================================================
    // Host end
    // ======================================================================
    typedef enum logic [2:0] {
        HPS_H_IDLE,
        HPS_H_SETUP,
        HPS_H_STROBE,
        HPS_H_HOLD,
        HPS_H_GAP
    } hps_host_state_e;

    typedef struct packed {
        hps_host_state_e st;
        logic [3:0] cnt;
        logic cs_n;
        logic ds_one;
        logic as_n;
        logic [1:0] acc_type;
        logic rd;
        logic half;
        logic [31:0] dout;
        logic oe_n;
        logic cmd_ready;
        logic rsp_valid;
        logic [31:0] rsp_data;
    } hps_host_s;

endpackage

`default_nettype wire

//--- testbench/host_port_strobe_handshake_tb.sv
// Self-checking bench joining both ends of the host port
`timescale 1ns/100ps
`default_nettype none
`include "hps_consts.svh"

module host_port_strobe_handshake_tb;
    logic clk_sys, rst, use_address_strobe, cmd_valid, cmd_ready, cmd_write, cmd_half, rsp_valid;
    logic sixteen_bit_mode, dma_read_req, dma_read_valid, write_buffer_full, write_push;
    logic [1:0] cmd_type, write_type;
    logic [31:0] cmd_data, rsp_data, dma_read_data, ctrl_read_data, write_data;
    int failures, samples_checked, dma_cnt, push_cnt;

    // ====================================================================
    // Both ends and the checker
    // ====================================================================
    hps_link_if link();
    hps_host_end #(.STB_LOW_CYC(4), .STB_HIGH_CYC(4)) u_hps_host_end (
        .clk_sys(clk_sys), .rst(rst), .link(link), .use_address_strobe(use_address_strobe),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_type(cmd_type),
        .cmd_half(cmd_half), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    hps_device_end u_hps_device_end (
        .clk_sys(clk_sys), .rst(rst), .link(link), .sixteen_bit_mode(sixteen_bit_mode),
        .dma_read_req(dma_read_req), .dma_read_data(dma_read_data), .dma_read_valid(dma_read_valid),
        .ctrl_read_data(ctrl_read_data), .write_buffer_full(write_buffer_full), .write_push(write_push),
        .write_data(write_data), .write_type(write_type));
    hps_link_props u_hps_link_props (
        .clk_sys(clk_sys), .rst(rst), .port_chip_select_n(link.port_chip_select_n),
        .data_strobe_one(link.data_strobe_one), .data_strobe_two(link.data_strobe_two),
        .address_strobe_n(link.address_strobe_n), .access_type_select(link.access_type_select),
        .read_write_select(link.read_write_select), .half_word_select(link.half_word_select),
        .port_ready_n(link.port_ready_n), .host_data_out(link.host_data_out),
        .host_data_oe_n(link.host_data_oe_n), .dev_data_out(link.dev_data_out),
        .dev_data_oe_n(link.dev_data_oe_n));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Late fetch answers make the stall visible
    initial
    begin
        dma_read_valid = 1'b0;
        forever
        begin
            @(negedge clk_sys);
            if (dma_read_req === 1'b1)
            begin
                dma_cnt++;
                repeat (5) @(negedge clk_sys);
                dma_read_valid = 1'b1;
                @(negedge clk_sys);
                dma_read_valid = 1'b0;
            end
        end
    end

    always @(negedge clk_sys)
    begin
        if (write_push === 1'b1)
        begin
            push_cnt++;
        end
    end

    // ====================================================================
    // Shared tasks
    // ====================================================================
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask

    task automatic do_cmd(input logic w, input logic [1:0] t, input logic h, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_type = t;
        cmd_half = h;
        cmd_data = d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 200)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("response seen", 32'(n < 200), 32'h1);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ====================================================================
    // Scenarios, sequence and watchdog
    // ====================================================================
    task automatic test_read32();
        int d0;
        d0 = dma_cnt;
        dma_read_data = 32'hc3a51e7f;
        do_cmd(1'b0, `HPS_ACC_DATA_INC, 1'b0, 32'h0);
        check("read word", rsp_data, 32'hc3a51e7f);
        check("fetch count", 32'(dma_cnt - d0), 32'h1);
        repeat (3) @(negedge clk_sys);
        check("bus released", link.port_data_bus, 32'hffffffff);
        $display("test_read32 done");
    endtask

    task automatic test_write_full();
        int p0;
        p0 = push_cnt;
        write_buffer_full = 1'b1;
        fork
            do_cmd(1'b1, `HPS_ACC_DATA_FIX, 1'b0, 32'h5a0f96e1);
            begin
                repeat (10) @(negedge clk_sys);
                check("ready stalled", 32'(link.port_ready_n), 32'h1);
                check("no early push", 32'(push_cnt - p0), 32'h0);
                write_buffer_full = 1'b0;
            end
        join
        repeat (3) @(negedge clk_sys);
        check("push count", 32'(push_cnt - p0), 32'h1);
        check("write word", write_data, 32'h5a0f96e1);
        check("write type", 32'(write_type), 32'(`HPS_ACC_DATA_FIX));
        $display("test_write_full done");
    endtask

    task automatic test_types();
        use_address_strobe = 1'b1;
        for (int t = 0; t < 4; t++)
        begin
            do_cmd(1'b1, 2'(t), 1'b0, 32'h1e000000 | 32'(t));
            repeat (3) @(negedge clk_sys);
            check("typed write type", 32'(write_type), 32'(t));
            check("typed write word", write_data, 32'h1e000000 | 32'(t));
        end
        ctrl_read_data = 32'h7e3c0d18;
        do_cmd(1'b0, `HPS_ACC_CTRL, 1'b0, 32'h0);
        check("control read", rsp_data, 32'h7e3c0d18);
        use_address_strobe = 1'b0;
        $display("test_types done");
    endtask

    task automatic test_half16();
        int d0;
        int p0;
        d0 = dma_cnt;
        sixteen_bit_mode = 1'b1;
        dma_read_data = 32'h6d29a4c7;
        do_cmd(1'b0, `HPS_ACC_DATA_INC, 1'b0, 32'h0);
        check("first half", 32'(rsp_data[15:0]), 32'h0000a4c7);
        // A second fetch would show as zero data
        dma_read_data = 32'h0;
        do_cmd(1'b0, `HPS_ACC_DATA_INC, 1'b1, 32'h0);
        check("second half", 32'(rsp_data[15:0]), 32'h00006d29);
        check("half fetches", 32'(dma_cnt - d0), 32'h1);
        p0 = push_cnt;
        do_cmd(1'b1, `HPS_ACC_DATA_INC, 1'b0, 32'h00003b5e);
        repeat (3) @(negedge clk_sys);
        check("half push early", 32'(push_cnt - p0), 32'h0);
        do_cmd(1'b1, `HPS_ACC_DATA_INC, 1'b1, 32'h000091f2);
        repeat (3) @(negedge clk_sys);
        check("half push", 32'(push_cnt - p0), 32'h1);
        check("joined word", write_data, 32'h91f23b5e);
        $display("test_half16 done");
    endtask

    initial
    begin
        rst = 1'b1;
        use_address_strobe = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_type = 2'h0;
        cmd_half = 1'b0;
        cmd_data = 32'h0;
        sixteen_bit_mode = 1'b0;
        dma_read_data = 32'h0;
        ctrl_read_data = 32'h0;
        write_buffer_full = 1'b0;
        repeat (12) @(negedge clk_sys);
        rst = 1'b0;
        test_read32();
        test_write_full();
        test_types();
        test_half16();
        wrap_up();
    end

    // Run ends well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end
endmodule // host_port_strobe_handshake_tb

`default_nettype wire

//--- testbench/hps_link_props.sv
// Assertions on the pins joining the two ends
`timescale 1ns/100ps
`default_nettype none

module hps_link_props (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic port_chip_select_n, // Select
    input wire logic data_strobe_one, // Strobe one
    input wire logic data_strobe_two, // Strobe two
    input wire logic address_strobe_n, // Address strobe
    input wire logic [1:0] access_type_select, // Type
    input wire logic read_write_select, // Direction
    input wire logic half_word_select, // Half
    input wire logic port_ready_n, // Ready
    input wire logic [31:0] host_data_out, // Host data
    input wire logic host_data_oe_n, // Host enable
    input wire logic [31:0] dev_data_out, // Device data
    input wire logic dev_data_oe_n // Device enable
);
    // ====================================================================
    // Combined strobe and properties
    // ====================================================================
    wire logic strobe_n = ~(data_strobe_one ^ data_strobe_two) | port_chip_select_n;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_fetch_stall;
        $fell(strobe_n) && read_write_select && access_type_select[1] && !half_word_select |=> port_ready_n;
    endproperty
    a_fetch_stall: assert property (p_fetch_stall) else $error("fetch read did not stall");
    property p_read_drive;
        $fell(strobe_n) && read_write_select |=> !dev_data_oe_n;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read bus not driven");
    property p_write_quiet;
        !strobe_n && !read_write_select |-> dev_data_oe_n;
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("device drove bus on a write");
    property p_release;
        $rose(strobe_n) |-> ##[1:2] dev_data_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("bus not released after strobe");
    property p_data_hold;
        !dev_data_oe_n && !port_ready_n && $past(!dev_data_oe_n && !port_ready_n) |-> $stable(dev_data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data moved while ready");
    property p_wait_ready;
        $rose(strobe_n) |-> $past(!port_ready_n);
    endproperty
    a_wait_ready: assert property (p_wait_ready) else $error("strobe released before ready");
    property p_low_width;
        $fell(strobe_n) |-> !strobe_n [*4];
    endproperty
    a_low_width: assert property (p_low_width) else $error("strobe low too short");
    property p_high_width;
        $rose(strobe_n) |-> strobe_n [*4];
    endproperty
    a_high_width: assert property (p_high_width) else $error("strobe high too short");
    property p_as_frame;
        $fell(address_strobe_n) |-> strobe_n ##1 (!strobe_n && !address_strobe_n);
    endproperty
    a_as_frame: assert property (p_as_frame) else $error("address strobe not across strobe fall");
    property p_wdata_hold;
        $rose(strobe_n) && !read_write_select |-> !host_data_oe_n && $stable(host_data_out);
    endproperty
    a_wdata_hold: assert property (p_wdata_hold) else $error("write data not held at strobe rise");

    c_fetch: cover property ($fell(strobe_n) && read_write_select && access_type_select[1]);
    c_write_stall: cover property ($fell(strobe_n) && !read_write_select ##1 port_ready_n);
    c_as_used: cover property ($fell(address_strobe_n));
endmodule // hps_link_props

`default_nettype wire
